// ===== rtl/bsc_buf2.v
// two-entry valid/ready buffer in the result path
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.vh"
module bsc_buf2 (
  input wire clk_i,
  input wire rst_n_i,
  input wire [12:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [12:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [12:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  reg ready_q;
  wire push = in_valid_i & ready_q;
  wire pop = out_ready_i & (cnt_q != 2'd0);
  assign in_ready_o = ready_q;
  assign out_valid_o = (cnt_q != 2'd0);
  assign out_data_o = mem_q[rd_q];
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'd0;
      ready_q <= 1'b1;
      mem_q[0] <= `BSC_RES_RST;
      mem_q[1] <= `BSC_RES_RST;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push & ~pop) begin
        cnt_q <= cnt_q + 2'd1;
        ready_q <= (cnt_q != 2'd1);
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 2'd1;
        ready_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bsc_core.v
// serial frame decoder, configuration registers and result shifter
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.vh"
module bsc_core (
  input wire clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire din_i,
  output reg dout_o,
  output reg dout_oe_o,
  output reg track_o,
  output reg [1:0] channel_o,
  output reg [1:0] range_o,
  output reg [1:0] input_config_o,
  output reg [1:0] power_mgmt_o,
  output reg ref_internal_o,
  output reg [7:0] range_reg_o,
  output reg [7:0] seq_reg_o,
  input wire [12:0] result_data_i,
  input wire result_valid_i,
  output wire result_ready_o
);
  // pin synchronisers feed edge detectors
  localparam NPIN = 3;
  localparam PIN_CS = 0;
  localparam PIN_SCLK = 1;
  localparam PIN_DIN = 2;
  localparam [NPIN-1:0] PIN_IDLE = 3'b011;
  wire [NPIN-1:0] pin_in;
  wire [NPIN-1:0] pin_s;
  reg cs_d3_q;
  reg sclk_d3_q;
  reg active_q;
  reg [`BSC_CNT_W-1:0] cnt_q;
  reg [14:0] rx_q;
  reg [15:0] tx_q;
  reg [`BSC_CTRL_W-1:0] ctrl_q;
  reg [1:0] seq_ch_q;
  reg [12:0] last_q;
  wire [12:0] buf_data;
  wire buf_valid;
  wire cs_fall;
  wire cs_rise;
  wire sclk_fall;
  wire din_s;
  wire sclk_edge;
  wire last_edge;
  wire [15:0] word;
  wire [1:0] wr_sel;
  wire wr_strobe;
  wire ctrl_wr;
  wire [1:0] addr;
  wire seq_on;
  wire [1:0] conv_ch;
  wire [12:0] raw;
  wire [12:0] code;
  genvar g;

  assign pin_in = {din_i, sclk_i, cs_n_i};
  assign cs_fall = cs_d3_q & ~pin_s[PIN_CS];
  assign cs_rise = ~cs_d3_q & pin_s[PIN_CS];
  assign sclk_fall = sclk_d3_q & ~pin_s[PIN_SCLK];
  assign din_s = pin_s[PIN_DIN];
  // sclk edges count only inside a frame, cs edges first
  assign sclk_edge = active_q & sclk_fall & ~cs_fall & ~cs_rise;
  assign last_edge = sclk_edge & (cnt_q == `BSC_LAST_EDGE);
  assign word = {rx_q, din_s};
  assign wr_sel = word[`BSC_SEL_HI:`BSC_SEL_LO];
  assign wr_strobe = last_edge & word[`BSC_WR_BIT];
  assign ctrl_wr = wr_strobe & (wr_sel == `BSC_SEL_CTRL);
  assign addr = ctrl_q[`BSC_C_ADDR_HI:`BSC_C_ADDR_LO];
  assign seq_on = ctrl_q[`BSC_C_SEQ_HI:`BSC_C_SEQ_LO] != `BSC_SEQ_OFF;
  assign conv_ch = seq_on ? seq_ch_q : addr;
  assign raw = buf_valid ? buf_data : last_q;
  // offset-binary code in, msb flipped for twos complement
  assign code = ctrl_q[`BSC_C_CODING] ? raw :
                {~raw[12], raw[11:0]};

  function [1:0] range_of;
    input [1:0] ch;
    input [7:0] r;
    begin
      range_of = r[7 - 2 * ch -: 2];
    end
  endfunction

  bsc_buf2 u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(result_data_i),
    .in_valid_i(result_valid_i),
    .in_ready_o(result_ready_o),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(cs_fall)
  );

  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          s1_q <= PIN_IDLE[g];
          s2_q <= PIN_IDLE[g];
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
        end
      end
      assign pin_s[g] = s2_q;
    end
  endgenerate

  // edge detector delay, reset to the idle pin levels
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cs_d3_q <= 1'b1;
      sclk_d3_q <= 1'b1;
    end else begin
      cs_d3_q <= pin_s[PIN_CS];
      sclk_d3_q <= pin_s[PIN_SCLK];
    end
  end

  // frame bit counter and receive shifter
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      active_q <= 1'b0;
      cnt_q <= {`BSC_CNT_W{1'b0}};
      rx_q <= 15'h0000;
    end else if (cs_fall) begin
      active_q <= 1'b1;
      cnt_q <= {`BSC_CNT_W{1'b0}};
    end else if (cs_rise) begin
      active_q <= 1'b0;
    end else if (sclk_edge) begin
      cnt_q <= cnt_q + {{(`BSC_CNT_W-1){1'b0}}, 1'b1};
      rx_q <= word[14:0];
      if (last_edge)
        active_q <= 1'b0;
    end
  end

  // track and hold control
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      track_o <= 1'b1;
    end else if (cs_fall) begin
      track_o <= 1'b0;
    end else if (sclk_edge && cnt_q == `BSC_TRACK_EDGE) begin
      track_o <= 1'b1;
    end
  end

  // write-only registers, loaded at the sixteenth edge
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `BSC_CTRL_RST;
      range_reg_o <= `BSC_RANGE_RST;
      seq_reg_o <= `BSC_SEQ_RST;
    end else if (wr_strobe) begin
      case (wr_sel)
        `BSC_SEL_CTRL: begin
          ctrl_q <= word[`BSC_CTRL_HI:`BSC_CTRL_LO];
        end
        `BSC_SEL_RANGE: begin
          range_reg_o <= word[`BSC_REG8_HI:`BSC_REG8_LO];
        end
        `BSC_SEL_SEQ: begin
          seq_reg_o <= word[`BSC_REG8_HI:`BSC_REG8_LO];
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // sequence position, restarts on each control write
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      seq_ch_q <= 2'b00;
    end else if (cs_fall) begin
      if (seq_on)
        seq_ch_q <= (seq_ch_q == addr) ? 2'b00 : seq_ch_q + 2'b01;
    end else if (ctrl_wr) begin
      seq_ch_q <= 2'b00;
    end
  end

  // settings frozen at hold so a write in this frame waits
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      channel_o <= 2'b00;
      range_o <= 2'b00;
      input_config_o <= `BSC_MODE_SE4;
      power_mgmt_o <= 2'b00;
      ref_internal_o <= 1'b0;
      last_q <= `BSC_RES_RST;
    end else if (cs_fall) begin
      channel_o <= conv_ch;
      range_o <= range_of(conv_ch, range_reg_o);
      input_config_o <= ctrl_q[`BSC_C_MODE_HI:`BSC_C_MODE_LO];
      power_mgmt_o <= ctrl_q[`BSC_C_PM_HI:`BSC_C_PM_LO];
      ref_internal_o <= ctrl_q[`BSC_C_REF];
      last_q <= raw;
    end
  end

  // result shifter, channel bits lead the code
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_q <= 16'h0000;
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
    end else if (cs_fall) begin
      tx_q <= {conv_ch[0], code, 2'b00};
      dout_o <= conv_ch[1];
      dout_oe_o <= 1'b1;
    end else if (cs_rise) begin
      dout_oe_o <= 1'b0;
    end else if (sclk_edge) begin
      dout_o <= tx_q[15];
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bsc_defines.vh
// constants for the bipolar sar conversion control block
// Operation
// - separate input range kept per channel
// - two config bits choose input arrangement
// - power-up arrangement is four single-ended
// - serial clock edges drive conversion and shifting
// - external reference until reference bit written
// - power management bits select power-down mode
// - twos complement default, format bit gives binary
// - sequence uses coding of latest control write
// - thirteen-bit result, step is span over 8192
// - track resumes on fifteenth falling clock edge
// - hold starts at chip select falling edge
// - sixteen-clock frame, write flag plus select
// - decode write flag and select into registers
// - address picks channel or sequence end channel
// - new configuration applies from next conversion
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH
`define BSC_FRAME_BITS 16
`define BSC_CNT_W 5
`define BSC_TRACK_EDGE 5'd14
`define BSC_LAST_EDGE 5'd15
`define BSC_RES_W 13
`define BSC_WR_BIT 15
`define BSC_SEL_HI 14
`define BSC_SEL_LO 13
`define BSC_SEL_CTRL 2'b00
`define BSC_SEL_RANGE 2'b01
`define BSC_SEL_SEQ 2'b11
`define BSC_CTRL_HI 12
`define BSC_CTRL_LO 1
`define BSC_CTRL_W 12
`define BSC_CTRL_RST 12'h000
`define BSC_C_ADDR_HI 10
`define BSC_C_ADDR_LO 9
`define BSC_C_MODE_HI 8
`define BSC_C_MODE_LO 7
`define BSC_C_PM_HI 6
`define BSC_C_PM_LO 5
`define BSC_C_CODING 4
`define BSC_C_REF 3
`define BSC_C_SEQ_HI 2
`define BSC_C_SEQ_LO 1
`define BSC_REG8_HI 12
`define BSC_REG8_LO 5
`define BSC_RANGE_RST 8'h00
`define BSC_SEQ_RST 8'h00
`define BSC_SEQ_OFF 2'b00
`define BSC_MODE_SE4 2'b00
`define BSC_RES_RST 13'h0000
`endif

// ===== testbench/bsc_core_chk.sv
// port checker for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module bsc_core_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic track_o,
  input wire logic [1:0] channel_o,
  input wire logic [1:0] range_o,
  input wire logic [1:0] input_config_o,
  input wire logic [7:0] range_reg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  hold_at_start_a: assert property ($rose(dout_oe_o) |-> !track_o)
    else $error("no hold at frame start");
  cs_detect_a: assert property ($fell(cs_n_i) |-> ##[1:4] dout_oe_o)
    else $error("frame start late");
  idle_track_a: assert property (!dout_oe_o |-> track_o)
    else $error("hold outside frame");
  track_in_frame_a: assert property ($rose(track_o) |-> dout_oe_o)
    else $error("track after frame");
  cfg_stable_a: assert property (dout_oe_o && $past(dout_oe_o) |->
    $stable(input_config_o))
    else $error("config moved in frame");
  chan_range_a: assert property ($rose(dout_oe_o) |->
    range_o == range_reg_o[6-2*channel_o +: 2])
    else $error("wrong channel range");
  first_bit_a: assert property ($rose(dout_oe_o) |->
    dout_o == channel_o[1])
    else $error("wrong first bit");
  cs_close_a: assert property (cs_n_i [*6] |-> !dout_oe_o)
    else $error("frame not closed");
endmodule
bind bsc_core bsc_core_chk u_chk (.clk_i, .rst_n_i, .cs_n_i, .dout_o,
  .dout_oe_o, .track_o, .channel_o, .range_o, .input_config_o, .range_reg_o);
`default_nettype wire

// ===== testbench/bsc_host.sv
// host serial master model
`timescale 1ns/1ps
`default_nettype none
module bsc_host (
  input wire logic clk_i,
  input wire logic dout_i,
  output var logic cs_n_o,
  output var logic sclk_o,
  output var logic din_o
);
  logic [15:0] rx;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic frame(input logic [15:0] w);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din_o = w[i];
      repeat (5) @(negedge clk_i);
      rx = {rx[14:0], dout_i};
      sclk_o = 1'b0;
      repeat (5) @(negedge clk_i);
      sclk_o = 1'b1;
    end
    repeat (5) @(negedge clk_i);
    cs_n_o = 1'b1;
    din_o = ~din_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_bsc_core.sv
// testbench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb_bsc_core;
  logic clk_i = 0;
  logic rst_n_i = 0;
  logic cs_n, sclk, din, dout, oe, track, rf, rdy;
  logic [1:0] ch, rng, cfg, pm;
  logic [7:0] rreg, sreg;
  logic [12:0] res = 13'h1abc;
  logic vld = 1;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #4 clk_i = ~clk_i;
  bsc_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .dout_o(dout), .dout_oe_o(oe),
    .track_o(track), .channel_o(ch), .range_o(rng), .input_config_o(cfg),
    .power_mgmt_o(pm), .ref_internal_o(rf), .range_reg_o(rreg),
    .seq_reg_o(sreg), .result_data_i(res), .result_valid_i(vld),
    .result_ready_o(rdy));
  bsc_host host (.clk_i(clk_i), .dout_i(dout), .cs_n_o(cs_n),
    .sclk_o(sclk), .din_o(din));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset;
    repeat (4) @(negedge clk_i);
    chk(cfg, 2'b00);
    chk(rf, 1'b0);
    chk(track, 1'b1);
    chk(rdy, 1'b0);
    $display("t_reset end");
  endtask
  task automatic t_modes;
    logic [1:0] m;
    logic [1:0] p;
    p = 2'b00;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      host.frame({4'b1000, m, m, m, m[0], m[1], 4'b0000});
      chk(cfg, p);
      host.frame(16'h7fff);
      chk(cfg, m);
      chk(pm, m);
      chk(rf, m[1]);
      chk(ch, m);
      chk(host.rx, {m, m[0] ? res : {~res[12], res[11:0]}, 1'b0});
      p = m;
    end
    $display("t_modes end");
  endtask
  task automatic t_regs;
    host.frame(16'ha360);
    chk(rreg, 8'h1b);
    host.frame(16'hdfe0);
    chk(rreg, 8'h1b);
    chk(sreg, 8'h00);
    chk(rng, 2'b11);
    host.frame(16'hf4a0);
    chk(sreg, 8'ha5);
    $display("t_regs end");
  endtask
  task automatic t_seq;
    logic [1:0] e;
    host.frame(16'h8824);
    for (int i = 0; i < 4; i++) begin
      e = (i == 3) ? 2'b00 : i[1:0];
      host.frame(16'h0000);
      chk(ch, e);
      chk(rng, e);
      chk(host.rx, {e, res, 1'b0});
    end
    $display("t_seq end");
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1;
    t_reset();
    t_modes();
    t_regs();
    t_seq();
    test_done();
  end
endmodule
`default_nettype wire
